// ---- aatc_consts.vh ----
`ifndef AATC_CONSTS_VH
`define AATC_CONSTS_VH

// register indices; byte address is four times the index
`define AATC_IDX_PWR_MGMT5     8'h0c
`define AATC_IDX_INT_STATUS2   8'h1a
`define AATC_IDX_INT_MASK2     8'h22
`define AATC_IDX_CMP_CTRL      8'ha3
`define AATC_IDX_CMP1_SETUP    8'ha4
`define AATC_IDX_CMP2_SETUP    8'ha5
`define AATC_IDX_CMP3_SETUP    8'ha6
`define AATC_IDX_CMP4_SETUP    8'ha7

// field positions
`define AATC_ENA_LSB           0
`define AATC_ENA_MSB           3
`define AATC_SRC_LSB           13
`define AATC_SRC_MSB           15
`define AATC_DIR_BIT           12
`define AATC_THR_LSB           0
`define AATC_THR_MSB           11
`define AATC_FLAG_LSB          4
`define AATC_FLAG_MSB          8

// reset values
`define AATC_ENA_RST           4'h0
`define AATC_SETUP_RST         16'h0000
`define AATC_FLAG_RST          5'h00
`define AATC_MASK_RST          5'h00

`endif

// ---- aatc_compare_irq.v ----
`timescale 1ns/1ps
`include "aatc_consts.vh"
module aatc_compare_irq #(
  parameter ADDR_W = 12,
  parameter NCMP   = 4
) (
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  input  wire              meas_valid,
  input  wire [2:0]        meas_channel,
  input  wire [11:0]       meas_code,
  output wire              aux_converter_system_irq
);

  localparam [ADDR_W-1:0] A_PM5   = {{(ADDR_W-10){1'b0}}, `AATC_IDX_PWR_MGMT5, 2'b00};
  localparam [ADDR_W-1:0] A_STAT  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_INT_STATUS2, 2'b00};
  localparam [ADDR_W-1:0] A_MASK  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_INT_MASK2, 2'b00};
  localparam [ADDR_W-1:0] A_CTRL  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_CMP_CTRL, 2'b00};
  localparam [ADDR_W-1:0] A_CMP1  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_CMP1_SETUP, 2'b00};
  localparam [ADDR_W-1:0] A_CMP2  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_CMP2_SETUP, 2'b00};
  localparam [ADDR_W-1:0] A_CMP3  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_CMP3_SETUP, 2'b00};
  localparam [ADDR_W-1:0] A_CMP4  = {{(ADDR_W-10){1'b0}}, `AATC_IDX_CMP4_SETUP, 2'b00};

  wire [NCMP-1:0]   comparator_enable_q;
  wire [15:0]       setup_q [0:NCMP-1];
  wire [4:0]        flag_q;
  wire [4:0]        mask_q;
  reg               wr_pend_q;
  reg  [ADDR_W-1:0] wr_addr_q;
  reg  [31:0]       rd_data_d;
  reg               wr_ena;
  reg               wr_mask;
  reg  [NCMP-1:0]   wr_cmp;
  wire [4:0]        flag_set;
  wire [4:0]        flag_clr;
  wire              xfer;
  wire              rd_take;
  wire              stat_rd;
  wire              stat_wr;
  wire [NCMP-1:0]   hit;

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign xfer    = hsel & htrans[1] & hready;
  assign rd_take = xfer & ~hwrite;
  assign stat_rd = rd_take & (haddr == A_STAT);
  assign stat_wr = wr_pend_q & (wr_addr_q == A_STAT);

  // four comparators; several may share one channel
  aatc_cmp_unit u_cmp1 (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .enable       (comparator_enable_q[0]),
    .setup        (setup_q[0]),
    .meas_valid   (meas_valid),
    .meas_channel (meas_channel),
    .meas_code    (meas_code),
    .hit          (hit[0])
  );

  aatc_cmp_unit u_cmp2 (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .enable       (comparator_enable_q[1]),
    .setup        (setup_q[1]),
    .meas_valid   (meas_valid),
    .meas_channel (meas_channel),
    .meas_code    (meas_code),
    .hit          (hit[1])
  );

  aatc_cmp_unit u_cmp3 (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .enable       (comparator_enable_q[2]),
    .setup        (setup_q[2]),
    .meas_valid   (meas_valid),
    .meas_channel (meas_channel),
    .meas_code    (meas_code),
    .hit          (hit[2])
  );

  aatc_cmp_unit u_cmp4 (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .enable       (comparator_enable_q[3]),
    .setup        (setup_q[3]),
    .meas_valid   (meas_valid),
    .meas_channel (meas_channel),
    .meas_code    (meas_code),
    .hit          (hit[3])
  );

  // sticky flags, read clears all, write of one clears that bit
  assign flag_set = {meas_valid, hit};
  assign flag_clr = {5{stat_rd}}
                    | ({5{stat_wr}} & hwdata[`AATC_FLAG_MSB:`AATC_FLAG_LSB]);

  aatc_flag_bit u_flag_cmp1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (flag_set[0]),
    .clr     (flag_clr[0]),
    .flag_q  (flag_q[0])
  );

  aatc_flag_bit u_flag_cmp2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (flag_set[1]),
    .clr     (flag_clr[1]),
    .flag_q  (flag_q[1])
  );

  aatc_flag_bit u_flag_cmp3 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (flag_set[2]),
    .clr     (flag_clr[2]),
    .flag_q  (flag_q[2])
  );

  aatc_flag_bit u_flag_cmp4 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (flag_set[3]),
    .clr     (flag_clr[3]),
    .flag_q  (flag_q[3])
  );

  aatc_flag_bit u_flag_ready (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (flag_set[4]),
    .clr     (flag_clr[4]),
    .flag_q  (flag_q[4])
  );

  assign aux_converter_system_irq = |(flag_q & ~mask_q);

  // write data phase capture
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {ADDR_W{1'b0}};
    end
    else
    begin
      wr_pend_q <= xfer & hwrite;
      if (xfer & hwrite)
        wr_addr_q <= haddr;
    end
  end

  // write decode in the data phase
  always @*
  begin
    wr_ena  = 1'b0;
    wr_mask = 1'b0;
    wr_cmp  = {NCMP{1'b0}};
    if (!wr_pend_q)
      wr_ena = 1'b0;
    else if (wr_addr_q == A_PM5 || wr_addr_q == A_CTRL)
      wr_ena = 1'b1;
    else if (wr_addr_q == A_MASK)
      wr_mask = 1'b1;
    else if (wr_addr_q == A_CMP1)
      wr_cmp[0] = 1'b1;
    else if (wr_addr_q == A_CMP2)
      wr_cmp[1] = 1'b1;
    else if (wr_addr_q == A_CMP3)
      wr_cmp[2] = 1'b1;
    else if (wr_addr_q == A_CMP4)
      wr_cmp[3] = 1'b1;
  end

  // one enable storage behind two addresses
  aatc_cfg_reg #(
    .WIDTH (NCMP),
    .RST   (`AATC_ENA_RST)
  ) u_reg_enable (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_ena),
    .wr_data (hwdata[`AATC_ENA_MSB:`AATC_ENA_LSB]),
    .value_q (comparator_enable_q)
  );

  aatc_cfg_reg #(
    .WIDTH (5),
    .RST   (`AATC_MASK_RST)
  ) u_reg_mask (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_mask),
    .wr_data (hwdata[`AATC_FLAG_MSB:`AATC_FLAG_LSB]),
    .value_q (mask_q)
  );

  aatc_cfg_reg #(
    .WIDTH (16),
    .RST   (`AATC_SETUP_RST)
  ) u_reg_cmp1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_cmp[0]),
    .wr_data (hwdata[15:0]),
    .value_q (setup_q[0])
  );

  aatc_cfg_reg #(
    .WIDTH (16),
    .RST   (`AATC_SETUP_RST)
  ) u_reg_cmp2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_cmp[1]),
    .wr_data (hwdata[15:0]),
    .value_q (setup_q[1])
  );

  aatc_cfg_reg #(
    .WIDTH (16),
    .RST   (`AATC_SETUP_RST)
  ) u_reg_cmp3 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_cmp[2]),
    .wr_data (hwdata[15:0]),
    .value_q (setup_q[2])
  );

  aatc_cfg_reg #(
    .WIDTH (16),
    .RST   (`AATC_SETUP_RST)
  ) u_reg_cmp4 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_cmp[3]),
    .wr_data (hwdata[15:0]),
    .value_q (setup_q[3])
  );

  // read mux, unmapped reads zero
  always @*
  begin
    rd_data_d = 32'h0000_0000;
    if (haddr == A_PM5 || haddr == A_CTRL)
      rd_data_d[`AATC_ENA_MSB:`AATC_ENA_LSB] = comparator_enable_q;
    else if (haddr == A_STAT)
      rd_data_d[`AATC_FLAG_MSB:`AATC_FLAG_LSB] = flag_q;
    else if (haddr == A_MASK)
      rd_data_d[`AATC_FLAG_MSB:`AATC_FLAG_LSB] = mask_q;
    else if (haddr == A_CMP1)
      rd_data_d[15:0] = setup_q[0];
    else if (haddr == A_CMP2)
      rd_data_d[15:0] = setup_q[1];
    else if (haddr == A_CMP3)
      rd_data_d[15:0] = setup_q[2];
    else if (haddr == A_CMP4)
      rd_data_d[15:0] = setup_q[3];
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= rd_data_d;
  end

endmodule

module aatc_cmp_unit (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        enable,
  input  wire [15:0] setup,
  input  wire        meas_valid,
  input  wire [2:0]  meas_channel,
  input  wire [11:0] meas_code,
  output wire        hit
);

  wire [2:0]  src;
  wire        gt;
  wire [11:0] thr;
  wire        sees;
  wire        cond;
  reg         cond_prev_q;

  assign src  = setup[`AATC_SRC_MSB:`AATC_SRC_LSB];
  assign gt   = setup[`AATC_DIR_BIT];
  assign thr  = setup[`AATC_THR_MSB:`AATC_THR_LSB];
  // raw code against raw threshold, strict either way
  assign cond = gt ? (meas_code > thr) : (meas_code < thr);
  assign sees = enable & meas_valid & (meas_channel == src);
  assign hit  = sees & cond & ~cond_prev_q;

  // history cleared while disabled so a re-enable can flag
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cond_prev_q <= 1'b0;
    else if (!enable)
      cond_prev_q <= 1'b0;
    else if (sees)
      cond_prev_q <= cond;
  end

endmodule

module aatc_flag_bit (
  input  wire hclk,
  input  wire hresetn,
  input  wire set,
  input  wire clr,
  output reg  flag_q
);

  // set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag_q <= 1'b0;
    else if (set)
      flag_q <= 1'b1;
    else if (clr)
      flag_q <= 1'b0;
  end

endmodule

module aatc_cfg_reg #(
  parameter             WIDTH = 16,
  parameter [WIDTH-1:0] RST   = {WIDTH{1'b0}}
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output reg  [WIDTH-1:0] value_q
);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      value_q <= RST;
    else if (wr_en)
      value_q <= wr_data;
  end

endmodule

// ---- aatc_compare_irq_asserts.sv ----
`timescale 1ns/1ps
module aatc_chk #(parameter ADDR_W = 12, parameter NCMP = 4) (
  input wire              hclk,
  input wire              hresetn,
  input wire              hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire [31:0]       hwdata,
  input wire              hready,
  input wire [31:0]       hrdata,
  input wire              meas_valid,
  input wire              aux_converter_system_irq
);
  reg              wv_q;
  reg              m8_q;
  reg [ADDR_W-1:0] wa_q;
  wire             irq = aux_converter_system_irq;
  wire             rd = hsel && htrans[1] && hready && !hwrite;
  wire             rs = rd && haddr == 12'h068;
  wire             wm = wv_q && wa_q == 12'h088;
  wire             ws = wv_q && wa_q == 12'h068;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) wv_q <= 1'b0;
    else wv_q <= hsel && htrans[1] && hready && hwrite;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) m8_q <= 1'b0;
    else if (wm) m8_q <= hwdata[8];
  always @(posedge hclk)
    if (hsel && htrans[1] && hready) wa_q <= haddr;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_clears: assert property (rs && !meas_valid |=> !irq) else $error("irq stays");
  a_irq_cause: assert property ($rose(irq) |-> $past(meas_valid) || $past(wm))
    else $error("irq rose without cause");
  a_irq_drop: assert property ($fell(irq) |-> $past(rs) || $past(wm) || $past(ws))
    else $error("irq fell without cause");
  a_status_bits: assert property (rs |=> (hrdata & 32'hfffffe0f) == 0)
    else $error("status stray bits");
  a_mask_bits: assert property (rd && haddr == 12'h088 |=> (hrdata & 32'hfffffe0f) == 0)
    else $error("mask stray bits");
  a_enable_bits: assert property (rd && (haddr == 12'h030 || haddr == 12'h28c)
    |=> hrdata[31:4] == 0) else $error("enable stray bits");
  a_setup_bits: assert property (rd && haddr[11:4] == 8'h29 |=> hrdata[31:16] == 0)
    else $error("setup stray bits");
  a_ready_irq: assert property (meas_valid && !m8_q && !wm |=> irq)
    else $error("no irq on data");
  cover property (rs && irq);
  cover property ($rose(irq));
  cover property (wm);
endmodule
bind aatc_compare_irq aatc_chk #(.ADDR_W(ADDR_W), .NCMP(NCMP)) u_chk (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .meas_valid, .aux_converter_system_irq);

// ---- aatc_adc_model.sv ----
`timescale 1ns/1ps
module aatc_adc_model (
  input  wire        hclk,
  output reg         meas_valid,
  output reg  [2:0]  meas_channel,
  output reg  [11:0] meas_code
);
  initial {meas_valid, meas_channel, meas_code} = 16'h0000;
  task put(input [2:0] ch, input [11:0] cd);
    begin
      @(posedge hclk);
      meas_valid <= 1'b1;
      meas_channel <= ch;
      meas_code <= cd;
      @(posedge hclk);
      meas_valid <= 1'b0;
      meas_channel <= ~ch;
      meas_code <= ~cd;
    end
  endtask
endmodule

// ---- aatc_compare_irq_tb.sv ----
`timescale 1ns/1ps
module aatc_compare_irq_tb;
  reg         hclk, hresetn, hsel, hwrite;
  reg  [11:0] haddr;
  reg  [1:0]  htrans;
  reg  [31:0] hwdata, q, e;
  wire [31:0] hrdata;
  wire        hready, meas_valid, aux_converter_system_irq;
  wire [2:0]  meas_channel;
  wire [11:0] meas_code;
  integer     n_errors = 0, n_checks = 0, i;
  localparam [107:0] RA = {12'h030, 12'h068, 12'h088, 12'h28c, 12'h290, 12'h294, 12'h298,
    12'h29c, 12'h100};
  localparam [223:0] ST = {32'h01000100, 32'h61000110, 32'h62000100, 32'h69000120,
    32'h69000100, 32'h64000100, 32'h63ff0110};
  aatc_compare_irq dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata, .meas_valid, .meas_channel,
    .meas_code, .aux_converter_system_irq);
  aatc_adc_model m (.hclk, .meas_valid, .meas_channel, .meas_code);
  initial
  begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end
  task chk(input [31:0] s, input [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (s !== x)
      begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task wt;
    integer k;
    begin
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && k < 50)
      begin
        k = k + 1;
        @(posedge hclk);
      end
      if (hready !== 1'b1) n_errors = n_errors + 1;
      if (hready !== 1'b1) give_verdict;
    end
  endtask
  task bus(input [11:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wt;
      htrans <= 2'b00;
      hwdata <= d;
      wt;
      q = hrdata;
    end
  endtask
  task t_resets;
    for (i = 0; i < 9; i = i + 1)
    begin
      bus(RA[i*12 +: 12], 1'b0, 32'h0);
      chk(q, 32'h0);
    end
  endtask
  task t_config;
    begin
      bus(12'h030, 1'b1, 32'hf);
      bus(12'h28c, 1'b0, 32'h0);
      chk(q, 32'hf);
      bus(12'h28c, 1'b1, 32'h3);
      bus(12'h030, 1'b0, 32'h0);
      chk(q, 32'h3);
      bus(12'h290, 1'b1, 32'hc400);
      bus(12'h294, 1'b1, 32'hd800);
      bus(12'h294, 1'b0, 32'h0);
      chk(q, 32'hd800);
    end
  endtask
  task t_compare;
    begin
      for (i = 0; i < 7; i = i + 1)
      begin
        e = ST[(6-i)*32 +: 32];
        m.put(e[30:28], e[27:16]);
        #1 chk(aux_converter_system_irq, 32'h1);
        @(posedge hclk);
        bus(12'h068, 1'b0, 32'h0);
        chk(q, e[15:0]);
      end
      bus(12'h068, 1'b0, 32'h0);
      chk(q, 32'h0);
    end
  endtask
  task t_mask;
    begin
      bus(12'h088, 1'b1, 32'h1f0);
      m.put(3'h6, 12'h100);
      #1 chk(aux_converter_system_irq, 32'h0);
      @(posedge hclk);
      bus(12'h088, 1'b1, 32'h0f0);
      #1 chk(aux_converter_system_irq, 32'h1);
      @(posedge hclk);
      bus(12'h068, 1'b0, 32'h0);
      #1 chk(aux_converter_system_irq, 32'h0);
      chk(q, 32'h100);
    end
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = 48'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_resets;
    t_config;
    t_compare;
    t_mask;
    give_verdict;
  end
endmodule
